//--- mabe_core.sv
`default_nettype none
// Notes on behaviour
// - add two registers, optional carry, one clock, update Z C N V H.
// - word add/subtract immediate on register pair, two clocks, Z C N V S.
// - subtract register or constant, optional borrow, one clock, Z C N V H.
// - and, or with register or constant, xor with register, one clock, only Z N V S.
// - mask set, mask clear, test, clear register: one clock, only Z N V S.
// - unsigned, signed, mixed multiply into r1:r0, two clocks, Z and C.
// - fractional multiplies shift product left one, two clocks, Z and C.
// - pointer goto/invoke load pc from Z pair, two/three clocks, no flags.
// - equal skip passes next instruction when equal, one to three clocks.
// - compares compute difference, no write, Z N V C H, one clock.
// - register bit skips skip next when bit clear or set, 1..3 clocks.
// - io bit skips test io register bit, skip when clear or set.
// - status branch tests any flag, pc+k+1 when true, one or two clocks.
// - carry branches on C set (lower) or clear (same or higher).
// - signed branches on N xor V; sign branches on N.
// - half-carry and transfer branches on H or T set or clear.
module mabe_core
	import mabe_pkg::*;
#(
	parameter int PC_WIDTH = 16
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// instruction issue
	input  wire logic                op_valid,
	input  wire mabe_op_type         op_code,
	input  wire logic [4:0]          op_rd,
	input  wire logic [4:0]          op_rr,
	input  wire logic [7:0]          op_imm,
	input  wire logic [2:0]          op_bit,
	input  wire logic [11:0]         op_offset,
	input  wire logic                next_is_long,
	// io bit under test
	input  wire logic [7:0]          io_value,
	// status
	output logic                     busy_q,
	output logic [PC_WIDTH-1:0]      pc_q,
	output logic [7:0]               flags_q,
	output logic                     push_q,
	output logic [PC_WIDTH-1:0]      push_addr_q
);
	// elaboration check: relative target and pointer cast need this range
	if (PC_WIDTH < 16 || PC_WIDTH > 22) begin : g_pc_width_check
		$error("PC_WIDTH out of range");
	end

	// ==============================================================
	// operand fetch
	logic [7:0] regs_q [32];
	logic [7:0] a_v, b_v;
	logic [15:0] ptr_v, pair_v;
	assign a_v    = regs_q[op_rd];
	assign b_v    = regs_q[op_rr];
	assign ptr_v  = {regs_q[REG_PTR_HI], regs_q[REG_PTR_LO]};
	assign pair_v = {regs_q[op_rd + 5'd1], a_v};

	function automatic logic is_mul(input mabe_op_type o);
		return o inside {OP_MULU, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED_SIGN, OP_FMULU, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED};
	endfunction

	// ==============================================================
	// arithmetic and logic
	logic [7:0]  res_d;
	logic        wr_en;
	logic [7:0]  fl_d;
	logic [15:0] wres_d;
	logic [15:0] prod_d;
	logic        take_d;
	logic [1:0]  extra_d;
	logic [PC_WIDTH-1:0] tgt_d;
	logic [PC_WIDTH-1:0] rel_v;
	logic [7:0]  opb;
	logic        cin, is_sub;
	logic [8:0]  sum9;
	logic [4:0]  h5;
	logic signed [17:0] sp;
	logic [PC_WIDTH-1:0] skip_pc;
	logic        cond;

	assign rel_v   = pc_q + {{(PC_WIDTH-12){op_offset[11]}}, op_offset} + 1'b1;
	assign skip_pc = pc_q + (next_is_long ? PC_WIDTH'(3) : PC_WIDTH'(2));

	always_comb begin
		res_d   = a_v;
		wr_en   = 1'b0;
		fl_d    = flags_q;
		wres_d  = pair_v;
		prod_d  = '0;
		take_d  = 1'b0;
		extra_d = 2'd0;
		tgt_d   = pc_q + 1'b1;
		opb     = op_imm;
		cin     = 1'b0;
		is_sub  = 1'b0;
		sum9    = '0;
		h5      = '0;
		sp      = '0;
		cond    = 1'b0;
		unique case (op_code)
			OP_ADD, OP_ADC, OP_SUB, OP_IMMEDIATE_DIFFERENCE, OP_SBC, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, OP_CMP, OP_CMPB, OP_CMPI: begin
				is_sub = !(op_code inside {OP_ADD, OP_ADC});
				opb = (op_code inside {OP_IMMEDIATE_DIFFERENCE, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, OP_CMPI}) ? op_imm : b_v;
				cin = (op_code inside {OP_ADC, OP_SBC, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, OP_CMPB}) ? flags_q[FLAG_C] : 1'b0;
				if (is_sub) begin
					sum9 = {1'b0, a_v} - {1'b0, opb} - {8'h00, cin};
					h5   = {1'b0, a_v[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
					fl_d[FLAG_V] = (a_v[7] & ~opb[7] & ~sum9[7]) | (~a_v[7] & opb[7] & sum9[7]);
				end else begin
					sum9 = {1'b0, a_v} + {1'b0, opb} + {8'h00, cin};
					h5   = {1'b0, a_v[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
					fl_d[FLAG_V] = (a_v[7] == opb[7]) && (sum9[7] != a_v[7]);
				end
				res_d = sum9[7:0];
				wr_en = !(op_code inside {OP_CMP, OP_CMPB, OP_CMPI});
				// borrow variants keep Z set only if already set
				fl_d[FLAG_Z] = (op_code inside {OP_SBC, OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, OP_CMPB}) ?
					((sum9[7:0] == 8'h00) & flags_q[FLAG_Z]) : (sum9[7:0] == 8'h00);
				fl_d[FLAG_C] = sum9[8];
				fl_d[FLAG_N] = sum9[7];
				fl_d[FLAG_H] = h5[4];
				fl_d[FLAG_S] = sum9[7] ^ fl_d[FLAG_V];
			end
			OP_AND, OP_IMMEDIATE_CONJUNCTION, OP_OR, OP_ORI, OP_EOR, OP_SETMASK, OP_CLRMASK, OP_ZSTEST, OP_CLEAR: begin
				unique case (op_code)
					OP_AND:     res_d = a_v & b_v;
					OP_IMMEDIATE_CONJUNCTION:    res_d = a_v & op_imm;
					OP_OR:      res_d = a_v | b_v;
					OP_ORI:     res_d = a_v | op_imm;
					OP_EOR:     res_d = a_v ^ b_v;
					OP_SETMASK: res_d = a_v | op_imm;
					OP_CLRMASK: res_d = a_v & ~op_imm;
					OP_ZSTEST:  res_d = a_v;
					default:    res_d = 8'h00;
				endcase
				wr_en = (op_code != OP_ZSTEST);
				fl_d[FLAG_Z] = (res_d == 8'h00);
				fl_d[FLAG_N] = res_d[7];
				fl_d[FLAG_V] = 1'b0;
				fl_d[FLAG_S] = res_d[7];
			end
			OP_ONES: begin
				res_d = 8'hff;
				wr_en = 1'b1; // flags untouched
			end
			OP_WPLUS, OP_WMINUS: begin
				extra_d = EXTRA_WORD;
				wres_d = (op_code == OP_WPLUS) ? pair_v + {10'h000, op_imm[5:0]}
					: pair_v - {10'h000, op_imm[5:0]};
				fl_d[FLAG_Z] = (wres_d == 16'h0000);
				fl_d[FLAG_N] = wres_d[15];
				fl_d[FLAG_V] = (op_code == OP_WPLUS) ? (~pair_v[15] & wres_d[15])
					: (pair_v[15] & ~wres_d[15]);
				fl_d[FLAG_C] = (op_code == OP_WPLUS) ? (pair_v[15] & ~wres_d[15])
					: (~pair_v[15] & wres_d[15]);
				fl_d[FLAG_S] = wres_d[15] ^ fl_d[FLAG_V];
			end
			OP_MULU, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED_SIGN, OP_FMULU, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED: begin
				extra_d = EXTRA_MUL;
				unique case (op_code)
					OP_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_SIGNED:   sp = $signed({{10{a_v[7]}}, a_v}) * $signed({{10{b_v[7]}}, b_v});
					OP_PRODUCT_MIXED_SIGN, OP_FRACTION_PRODUCT_MIXED: sp = $signed({{10{a_v[7]}}, a_v}) * $signed({10'h000, b_v});
					default:             sp = $signed({10'h000, a_v}) * $signed({10'h000, b_v});
				endcase
				fl_d[FLAG_C] = sp[15]; // carry is product bit 15 before the shift
				prod_d = (op_code inside {OP_FMULU, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED}) ?
					{sp[14:0], 1'b0} : sp[15:0];
				fl_d[FLAG_Z] = (prod_d == 16'h0000);
			end
			OP_RGOTO, OP_RINVOKE: begin
				take_d = 1'b1;
				tgt_d = rel_v;
				extra_d = (op_code == OP_RGOTO) ? EXTRA_GOTO : EXTRA_INVOKE;
			end
			OP_PGOTO, OP_PINVOKE: begin
				take_d = 1'b1;
				tgt_d = PC_WIDTH'(ptr_v);
				extra_d = (op_code == OP_PGOTO) ? EXTRA_GOTO : EXTRA_INVOKE;
			end
			OP_EQSKIP, OP_SKRLOW, OP_SKRHIGH, OP_SKIOLOW, OP_SKIOHIGH: begin
				unique case (op_code)
					OP_EQSKIP:  cond = (a_v == b_v);
					OP_SKRLOW:  cond = !b_v[op_bit];
					OP_SKRHIGH: cond = b_v[op_bit];
					OP_SKIOLOW: cond = !io_value[op_bit];
					default:    cond = io_value[op_bit];
				endcase
				if (cond) begin
					take_d = 1'b1;
					tgt_d = skip_pc;
					extra_d = next_is_long ? 2'd2 : 2'd1;
				end
			end
			OP_BRSET, OP_BRCLR: begin
				// named branches map to these with the flag index on op_bit
				cond = (flags_q[op_bit] == (op_code == OP_BRSET));
				if (cond) begin
					take_d = 1'b1;
					tgt_d = rel_v;
					extra_d = EXTRA_BRANCH;
				end
			end
			default: ;
		endcase
	end

	// ==============================================================
	// sequencer: holds busy for the extra cycles of long operations
	mabe_state_type st_q;
	logic [1:0]     cnt_q;
	logic           fire;
	assign fire = op_valid && (st_q == ST_IDLE);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= ST_IDLE;
			cnt_q  <= 2'd0;
			busy_q <= 1'b0;
		end else if (fire && extra_d != 2'd0) begin
			st_q   <= ST_WAIT;
			cnt_q  <= extra_d;
			busy_q <= 1'b1;
		end else if (st_q == ST_WAIT) begin
			cnt_q <= cnt_q - 2'd1;
			if (cnt_q == 2'd1) begin
				st_q   <= ST_IDLE;
				busy_q <= 1'b0;
			end
		end
	end

	// ==============================================================
	// program counter and return address for invokes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q        <= PC_WIDTH'(PC_RESET);
			push_q      <= 1'b0;
			push_addr_q <= '0;
		end else begin
			push_q <= 1'b0;
			if (fire) begin
				pc_q <= tgt_d;
				if (op_code inside {OP_RINVOKE, OP_PINVOKE}) begin
					push_q      <= 1'b1;
					push_addr_q <= pc_q + 1'b1;
				end
			end
		end
	end

	// ==============================================================
	// status flags: only arithmetic and logic groups change them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAGS_RESET;
		end else if (fire) begin
			flags_q <= fl_d;
		end
	end

	// ==============================================================
	// working registers; results land with the accepting edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) begin
				regs_q[i] <= REG_RESET;
			end
		end else if (fire) begin
			if (wr_en) begin
				regs_q[op_rd] <= res_d;
			end
			if (op_code inside {OP_WPLUS, OP_WMINUS}) begin
				regs_q[op_rd]        <= wres_d[7:0];
				regs_q[op_rd + 5'd1] <= wres_d[15:8];
			end
			if (is_mul(op_code)) begin
				regs_q[REG_PROD_LO] <= prod_d[7:0];
				regs_q[REG_PROD_HI] <= prod_d[15:8];
			end
		end
	end

	// ==============================================================
	// checks
	// carry is worked out from the operands, so a broken adder cannot hide it
	add_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_ADD
		|=> flags_q[FLAG_C] == $past(({1'b0, a_v} + {1'b0, b_v}) > 9'h0ff))
		else $error("add carry wrong");
	sub_borrow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_SUB |=> flags_q[FLAG_C] == $past(b_v > a_v))
		else $error("subtract borrow wrong");
	word_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_WPLUS |=> busy_q ##1 !busy_q)
		else $error("word op length wrong");
	logic_v_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code inside {OP_AND, OP_OR, OP_EOR} |=> !flags_q[FLAG_V]
		&& flags_q[FLAG_C] == $past(flags_q[FLAG_C]))
		else $error("logic flags wrong");
	mul_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && is_mul(op_code) |=> busy_q ##1 !busy_q)
		else $error("multiply length wrong");
	fraction_product_unsigned_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code inside {OP_FMULU, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED}
		|=> !regs_q[REG_PROD_LO][0])
		else $error("fraction product not shifted");
	invoke_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_RINVOKE
		|=> push_q && busy_q ##1 !push_q && busy_q ##1 !busy_q)
		else $error("invoke length wrong");
	ptr_goto_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_PGOTO |=> pc_q == PC_WIDTH'($past(ptr_v)))
		else $error("pointer goto target wrong");
	eq_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_EQSKIP && a_v == b_v && next_is_long
		|=> pc_q == $past(pc_q) + 3'd3 && busy_q ##1 busy_q ##1 !busy_q)
		else $error("equal skip wrong");
	cmp_nowrite_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code inside {OP_CMP, OP_CMPB, OP_CMPI}
		|=> regs_q[$past(op_rd)] == $past(a_v))
		else $error("compare writes register");
	io_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_SKIOLOW && io_value[op_bit]
		|=> pc_q == $past(pc_q) + 1'b1 && !busy_q)
		else $error("io skip taken wrongly");
	branch_pc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code == OP_BRSET && !flags_q[op_bit] |=> pc_q == $past(pc_q) + 1'b1
		&& !busy_q)
		else $error("untaken branch wrong");
	flow_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fire && op_code inside {OP_RGOTO, OP_EQSKIP, OP_BRCLR, OP_ONES}
		|=> $stable(flags_q))
		else $error("flags changed by flow op");
	cov_mul: cover property (@(posedge ref_clk) fire && op_code == OP_FRACTION_PRODUCT_SIGNED);
	cov_skip: cover property (@(posedge ref_clk) fire && op_code == OP_EQSKIP && take_d);
	cov_branch: cover property (@(posedge ref_clk) fire && op_code == OP_BRCLR && take_d);
	cov_invoke: cover property (@(posedge ref_clk) fire && op_code == OP_RINVOKE);
	cov_word: cover property (@(posedge ref_clk) fire && op_code == OP_WMINUS);
endmodule
`default_nettype wire

//--- mabe_pkg.sv
`default_nettype none
package mabe_pkg;
	// operation select codes presented on op_code
	typedef enum logic [5:0] {
		OP_NONE     = 6'h00,
		OP_ADD      = 6'h01,
		OP_ADC      = 6'h02,
		OP_SUB      = 6'h03,
		OP_IMMEDIATE_DIFFERENCE     = 6'h04,
		OP_SBC      = 6'h05,
		OP_IMMEDIATE_DIFFERENCE_WITH_BORROW     = 6'h06,
		OP_AND      = 6'h07,
		OP_IMMEDIATE_CONJUNCTION     = 6'h08,
		OP_OR       = 6'h09,
		OP_ORI      = 6'h0a,
		OP_EOR      = 6'h0b,
		OP_SETMASK  = 6'h0c,
		OP_CLRMASK  = 6'h0d,
		OP_ZSTEST   = 6'h0e,
		OP_CLEAR    = 6'h0f,
		OP_ONES     = 6'h10,
		OP_WPLUS    = 6'h11,
		OP_WMINUS   = 6'h12,
		OP_MULU     = 6'h13,
		OP_PRODUCT_SIGNED     = 6'h14,
		OP_PRODUCT_MIXED_SIGN    = 6'h15,
		OP_FMULU    = 6'h16,
		OP_FRACTION_PRODUCT_SIGNED    = 6'h17,
		OP_FRACTION_PRODUCT_MIXED   = 6'h18,
		OP_RGOTO    = 6'h19,
		OP_PGOTO    = 6'h1a,
		OP_RINVOKE  = 6'h1b,
		OP_PINVOKE  = 6'h1c,
		OP_EQSKIP   = 6'h1d,
		OP_CMP      = 6'h1e,
		OP_CMPB     = 6'h1f,
		OP_CMPI     = 6'h20,
		OP_SKRLOW   = 6'h21,
		OP_SKRHIGH  = 6'h22,
		OP_SKIOLOW  = 6'h23,
		OP_SKIOHIGH = 6'h24,
		OP_BRSET    = 6'h25,
		OP_BRCLR    = 6'h26
	} mabe_op_type;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01
	} mabe_state_type;

	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// register file layout
	localparam int REG_PROD_LO = 0;
	localparam int REG_PROD_HI = 1;
	localparam int REG_PTR_LO  = 30;
	localparam int REG_PTR_HI  = 31;

	// reset values
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam logic [7:0]  REG_RESET   = 8'h00;

	// cycle counts (extra cycles after the first)
	localparam logic [1:0] EXTRA_WORD   = 2'd1;
	localparam logic [1:0] EXTRA_MUL    = 2'd1;
	localparam logic [1:0] EXTRA_GOTO   = 2'd1;
	localparam logic [1:0] EXTRA_INVOKE = 2'd2;
	localparam logic [1:0] EXTRA_BRANCH = 2'd1;
endpackage
`default_nettype wire

//--- mcu_alu_branch_exec_tb_top.sv
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mcu_alu_branch_exec_tb_top
	import mabe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ======================================================
	// stimulus and observed signals
	logic        ref_clk, rst_n, op_valid, next_is_long, busy_q, push_q, pu;
	mabe_op_type op_code;
	logic [4:0]  op_rd, op_rr;
	logic [7:0]  op_imm, io_value, flags_q, f0;
	logic [2:0]  op_bit;
	logic [11:0] op_offset;
	logic [15:0] pc_q, push_addr_q, p0, pa;
	logic [3:0]  xtra;
	int          failures, n_compared;

	mabe_core #(.PC_WIDTH(16)) i_mabe_core (
		.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
		.op_rd(op_rd), .op_rr(op_rr), .op_imm(op_imm), .op_bit(op_bit),
		.op_offset(op_offset), .next_is_long(next_is_long), .io_value(io_value),
		.busy_q(busy_q), .pc_q(pc_q), .flags_q(flags_q), .push_q(push_q),
		.push_addr_q(push_addr_q));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ======================================================
	// shared tasks
	// one op; waits out busy so the next issue is never refused
	task automatic issue(input mabe_op_type op, input logic [4:0] rd, input logic [4:0] rr,
		input logic [7:0] imm, input logic [2:0] b, input logic [11:0] off, input logic lng);
		p0 = pc_q;
		f0 = flags_q;
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= op;
		op_rd <= rd;
		op_rr <= rr;
		op_imm <= imm;
		op_bit <= b;
		op_offset <= off;
		next_is_long <= lng;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		pu = push_q; // push pulse only stands this one cycle
		pa = push_addr_q;
		xtra = 4'h0;
		while (busy_q === 1'b1 && xtra < 4'h8) begin
			@(posedge ref_clk);
			#1;
			xtra++;
		end
	endtask

	task automatic r(input mabe_op_type op, input logic [4:0] rd, input logic [4:0] rr,
		input logic [7:0] imm);
		issue(op, rd, rr, imm, 3'h0, 12'h000, 1'b0);
	endtask

	task automatic cf(input logic [7:0] m, input logic [7:0] e, input logic [3:0] x);
		`CHK(flags_q & m, e)
		`CHK(xtra, x)
	endtask

	// flow ops: target, extra cycles, flags untouched
	task automatic cp(input logic [15:0] e, input logic [3:0] x);
		`CHK(pc_q, e)
		`CHK(xtra, x)
		`CHK(flags_q, f0)
	endtask

	// ======================================================
	// scenarios
	task automatic t_arith;
		r(OP_ONES, 5'h10, 5'h00, 8'h00); cf(8'hff, 8'h00, 4'h0);
		r(OP_ADD, 5'h10, 5'h10, 8'h00); cf(8'h2f, 8'h25, 4'h0);
		r(OP_ADC, 5'h11, 5'h10, 8'h00); cf(8'h2f, 8'h04, 4'h0);
		r(OP_IMMEDIATE_DIFFERENCE, 5'h11, 5'h00, 8'hff); cf(8'h2f, 8'h02, 4'h0);
		r(OP_IMMEDIATE_DIFFERENCE, 5'h11, 5'h00, 8'h01); cf(8'h2f, 8'h25, 4'h0);
		r(OP_CMPB, 5'h16, 5'h16, 8'h00); cf(8'h2f, 8'h25, 4'h0);
		r(OP_SBC, 5'h11, 5'h12, 8'h00); cf(8'h2f, 8'h04, 4'h0);
		r(OP_SUB, 5'h12, 5'h10, 8'h00); cf(8'h2f, 8'h21, 4'h0);
		r(OP_CMP, 5'h10, 5'h10, 8'h00); cf(8'h2f, 8'h02, 4'h0);
		r(OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, 5'h12, 5'h00, 8'h02); cf(8'h2f, 8'h02, 4'h0);
		r(OP_CMPI, 5'h10, 5'h00, 8'hfe); cf(8'h2f, 8'h02, 4'h0);
		$display("test arith done");
	endtask

	// carry and half-carry preset so an unwanted write shows
	task automatic t_logic;
		r(OP_SUB, 5'h13, 5'h10, 8'h00);
		r(OP_EOR, 5'h13, 5'h13, 8'h00); cf(8'h2f, 8'h23, 4'h0);
		r(OP_ORI, 5'h13, 5'h00, 8'h80); cf(8'h3f, 8'h35, 4'h0);
		r(OP_IMMEDIATE_CONJUNCTION, 5'h13, 5'h00, 8'h7f); cf(8'h2f, 8'h23, 4'h0);
		r(OP_OR, 5'h13, 5'h10, 8'h00); cf(8'h2f, 8'h25, 4'h0);
		r(OP_AND, 5'h13, 5'h12, 8'h00); cf(8'h2f, 8'h23, 4'h0);
		r(OP_SETMASK, 5'h13, 5'h00, 8'h81); cf(8'h2f, 8'h25, 4'h0);
		r(OP_CLRMASK, 5'h13, 5'h00, 8'h80); cf(8'h2f, 8'h21, 4'h0);
		r(OP_ZSTEST, 5'h10, 5'h00, 8'h00); cf(8'h2f, 8'h25, 4'h0);
		r(OP_CLEAR, 5'h13, 5'h00, 8'h00); cf(8'h2f, 8'h23, 4'h0);
		$display("test logic done");
	endtask

	task automatic t_mul;
		mabe_op_type ops[6] = '{OP_MULU, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED_SIGN, OP_FMULU, OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED};
		logic [7:0]  lo[6] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h02};
		logic [7:0]  hi[6] = '{8'hfe, 8'h00, 8'hff, 8'hfc, 8'h00, 8'hfe};
		logic [5:0]  cv = 6'h2d;
		r(OP_ONES, 5'h14, 5'h00, 8'h00);
		r(OP_ONES, 5'h15, 5'h00, 8'h00);
		for (int i = 0; i < 6; i++) begin
			r(ops[i], 5'h14, 5'h15, 8'h00); cf(8'h03, {7'h00, cv[i]}, 4'h1);
			r(OP_CMPI, 5'h00, 5'h00, lo[i]); `CHK(flags_q[FLAG_Z], 1'b1)
			r(OP_CMPI, 5'h01, 5'h00, hi[i]); `CHK(flags_q[FLAG_Z], 1'b1)
		end
		r(OP_MULU, 5'h14, 5'h16, 8'h00); cf(8'h03, 8'h02, 4'h1);
		$display("test mul done");
	endtask

	task automatic t_word;
		r(OP_WPLUS, 5'h18, 5'h00, 8'h3f); cf(8'h1f, 8'h00, 4'h1);
		r(OP_WMINUS, 5'h18, 5'h00, 8'h3f); cf(8'h1f, 8'h02, 4'h1);
		r(OP_WMINUS, 5'h18, 5'h00, 8'h01); cf(8'h1f, 8'h15, 4'h1);
		r(OP_CMPI, 5'h19, 5'h00, 8'hff); `CHK(flags_q[FLAG_Z], 1'b1)
		r(OP_WPLUS, 5'h18, 5'h00, 8'h01); cf(8'h1f, 8'h03, 4'h1);
		$display("test word done");
	endtask

	task automatic t_flow;
		issue(OP_RGOTO, 5'h00, 5'h00, 8'h00, 3'h0, 12'hffe, 1'b0);
		cp(p0 + 16'hffff, 4'h1);
		issue(OP_RINVOKE, 5'h00, 5'h00, 8'h00, 3'h0, 12'h005, 1'b0);
		cp(p0 + 16'h0006, 4'h2);
		`CHK({pu, pa}, {1'b1, p0 + 16'h0001})
		r(OP_WPLUS, 5'h1e, 5'h00, 8'h12);
		issue(OP_PGOTO, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'b0);
		cp(16'h0012, 4'h1);
		issue(OP_PINVOKE, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'b0);
		cp(16'h0012, 4'h2);
		`CHK({pu, pa}, {1'b1, 16'h0013})
		// request held through both busy edges: they must refuse it
		p0 = pc_q;
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= OP_RINVOKE;
		op_offset <= 12'h010;
		repeat (3) @(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		`CHK(pc_q, p0 + 16'h0011)
		$display("test flow done");
	endtask

	// io_value is 8'h5a: bit0 clear, bits 1 and 6 set
	task automatic t_skip;
		issue(OP_EQSKIP, 5'h14, 5'h15, 8'h00, 3'h0, 12'h000, 1'b1);
		cp(p0 + 16'h0003, 4'h2);
		issue(OP_EQSKIP, 5'h14, 5'h16, 8'h00, 3'h0, 12'h000, 1'b1);
		cp(p0 + 16'h0001, 4'h0);
		issue(OP_SKRLOW, 5'h00, 5'h16, 8'h00, 3'h0, 12'h000, 1'b0);
		cp(p0 + 16'h0002, 4'h1);
		issue(OP_SKRHIGH, 5'h00, 5'h16, 8'h00, 3'h0, 12'h000, 1'b1);
		cp(p0 + 16'h0001, 4'h0);
		issue(OP_SKRHIGH, 5'h00, 5'h14, 8'h00, 3'h7, 12'h000, 1'b1);
		cp(p0 + 16'h0003, 4'h2);
		issue(OP_SKIOLOW, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'b0);
		cp(p0 + 16'h0002, 4'h1);
		issue(OP_SKIOHIGH, 5'h00, 5'h00, 8'h00, 3'h1, 12'h000, 1'b1);
		cp(p0 + 16'h0003, 4'h2);
		issue(OP_SKIOLOW, 5'h00, 5'h00, 8'h00, 3'h6, 12'h000, 1'b0);
		cp(p0 + 16'h0001, 4'h0);
		$display("test skip done");
	endtask

	// flags preset to 8'h35, then every flag index both ways
	task automatic t_branch;
		logic tk;
		r(OP_ONES, 5'h1a, 5'h00, 8'h00);
		r(OP_SUB, 5'h1b, 5'h1a, 8'h00);
		r(OP_ORI, 5'h1b, 5'h00, 8'h80);
		for (int i = 0; i < 8; i++) begin
			for (int s = 0; s < 2; s++) begin
				tk = (8'h35 >> i) & 8'h01 ? (s == 1) : (s == 0);
				issue(mabe_op_type'(s ? OP_BRSET : OP_BRCLR), 5'h00, 5'h00, 8'h00,
					i[2:0], 12'h7ff, 1'b0);
				cp(tk ? p0 + 16'h0800 : p0 + 16'h0001, tk ? 4'h1 : 4'h0);
			end
		end
		$display("test branch done");
	endtask

	// ======================================================
	// run control
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		failures = 0;
		n_compared = 0;
		rst_n = 1'b0;
		op_valid = 1'b0;
		op_code = OP_NONE;
		op_rd = 5'h00;
		op_rr = 5'h00;
		op_imm = 8'h00;
		op_bit = 3'h0;
		op_offset = 12'h000;
		next_is_long = 1'b0;
		io_value = 8'h5a;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		t_arith;
		t_logic;
		t_mul;
		t_word;
		t_flow;
		t_skip;
		t_branch;
		report_and_stop;
	end

	// whole run needs well under 1000 cycles; a hang ends it here
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		$display("watchdog expired");
		report_and_stop;
	end
endmodule
`default_nettype wire
